/* File: shared/adcsel_pkg.sv */
`default_nettype none
package adcsel_pkg;
   // Register byte addresses
   localparam logic [31:0] ADCSEL_CFG_ADDR = 32'h0000_21A8;
   localparam logic [31:0] ADCSEL_STAT_ADDR = 32'h0000_21AC;
   localparam logic [31:0] ADCSEL_CFG_RESET = 32'h0000_0000;
   // Bits that software may change in the config word
   localparam logic [31:0] ADCSEL_CFG_WMASK = 32'h0007_FF3F;
   // Field positions and widths
   localparam int ADCSEL_GAIN_LSB = 16;
   localparam int ADCSEL_GAIN_W = 3;
   localparam int ADCSEL_OFS_BIT = 15;
   localparam int ADCSEL_SPARE_LSB = 13;
   localparam int ADCSEL_SPARE_W = 2;
   localparam int ADCSEL_NEG_LSB = 8;
   localparam int ADCSEL_NEG_W = 5;
   localparam int ADCSEL_POS_LSB = 0;
   localparam int ADCSEL_POS_W = 6;
   localparam int ADCSEL_GAIN_N = 5;
   // Status word bit positions
   localparam int ADCSEL_ST_NEG_RSV = 0;
   localparam int ADCSEL_ST_POS_RSV = 1;
   localparam int ADCSEL_ST_GAIN_RSV = 2;
   localparam int ADCSEL_ST_OFS_CONFLICT = 3;
   // Gain codes
   localparam logic [2:0] ADCSEL_GAIN_X1 = 3'h0;
   localparam logic [2:0] ADCSEL_GAIN_X1P5 = 3'h1;
   localparam logic [2:0] ADCSEL_GAIN_X2 = 3'h2;
   localparam logic [2:0] ADCSEL_GAIN_X4 = 3'h3;
   localparam logic [2:0] ADCSEL_GAIN_X9A = 3'h4;
   localparam logic [2:0] ADCSEL_GAIN_X9B = 3'h5;
   // Negative selector codes
   localparam logic [4:0] ADCSEL_NEG_FLOAT = 5'h00;
   localparam logic [4:0] ADCSEL_NEG_HS_TIA = 5'h01;
   localparam logic [4:0] ADCSEL_NEG_LP_TIA = 5'h02;
   localparam logic [4:0] ADCSEL_NEG_AUX0 = 5'h04;
   localparam logic [4:0] ADCSEL_NEG_BIAS_CAP = 5'h08;
   localparam logic [4:0] ADCSEL_NEG_THERMAL = 5'h0B;
   localparam logic [4:0] ADCSEL_NEG_AUX4 = 5'h0C;
   localparam logic [4:0] ADCSEL_NEG_EXC = 5'h14;
   // Positive selector codes
   localparam logic [5:0] ADCSEL_POS_FLOAT = 6'h00;
   localparam logic [5:0] ADCSEL_POS_HS_TIA = 6'h01;
   localparam logic [5:0] ADCSEL_POS_LP_FILT = 6'h02;
   localparam logic [5:0] ADCSEL_POS_THERMAL = 6'h0B;
   localparam logic [5:0] ADCSEL_POS_THERM_NEG = 6'h13;
   localparam logic [5:0] ADCSEL_POS_AUX4 = 6'h14;
   localparam logic [5:0] ADCSEL_POS_CE = 6'h19;
   localparam logic [5:0] ADCSEL_POS_RE = 6'h1A;
   localparam logic [5:0] ADCSEL_POS_CE_HALF = 6'h1F;
   localparam logic [5:0] ADCSEL_POS_LP_OUT = 6'h21;
   localparam logic [5:0] ADCSEL_POS_AGND = 6'h23;
   localparam logic [5:0] ADCSEL_POS_EXC = 6'h24;
   // Codes that are defined; all others are reserved
   localparam logic [31:0] ADCSEL_NEG_VALID = 32'h0013_59F7;
   localparam logic [63:0] ADCSEL_POS_VALID = 64'h0000_001A_EFDD_FFF7;
   // AHB-Lite encodings
   localparam logic [1:0] ADCSEL_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] ADCSEL_HTRANS_SEQ = 2'h3;
   localparam logic [2:0] ADCSEL_HSIZE_WORD = 3'h2;
endpackage
`default_nettype wire

/* File: src/adcsel_ahb_front.sv */
`default_nettype none
module adcsel_ahb_front (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite address phase
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] haddr,
   input wire logic hready,
   // Decoded requests
   output logic rd_take,
   output logic [31:0] rd_addr,
   output logic wr_pend,
   output logic [31:0] wr_addr
);
   import adcsel_pkg::*;

   typedef struct packed {
      logic wr_pend;
      logic [31:0] wr_addr;
   } adcsel_front_t;

   adcsel_front_t f_reg;
   adcsel_front_t f_next;
   logic take;

   // Address phase accepted when selected, active and bus ready
   assign take = hsel && hready &&
      (htrans == ADCSEL_HTRANS_NONSEQ || htrans == ADCSEL_HTRANS_SEQ);

   // Writes of a whole word move into the data phase
   always_comb begin
      f_next = f_reg;
      if (hready) begin
         f_next.wr_pend = take && hwrite && hsize == ADCSEL_HSIZE_WORD;
         f_next.wr_addr = haddr;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         f_reg <= '0;
      end else begin
         f_reg <= f_next;
      end
   end

   assign rd_take = take && !hwrite;
   assign rd_addr = haddr;
   assign wr_pend = f_reg.wr_pend;
   assign wr_addr = f_reg.wr_addr;
endmodule
`default_nettype wire

/* File: src/adcsel_route_dec.sv */
`default_nettype none
module adcsel_route_dec #(
   parameter int W = 5,
   parameter int N = 32,
   parameter logic [N-1:0] VALID = '1
) (
   // Selector code
   input wire logic [W-1:0] code,
   // One-hot route and reserved flag
   output logic [N-1:0] onehot,
   output logic reserved
);
   // Reserved codes fall back to the floating input
   assign reserved = !VALID[code]; // R12

   // One select line per defined code
   genvar i;
   generate
      for (i = 1; i < N; i++) begin : g_line
         localparam logic [W-1:0] IDX = W'(i);
         assign onehot[i] = VALID[i] && code == IDX;
      end
   endgenerate

   // Floating line for code zero or any reserved code
   assign onehot[0] = code == '0 || reserved; // R12
endmodule
`default_nettype wire

/* File: src/adcsel_top.sv */
// Summary of operation
// R1: Config word at 0x000021A8, every field cleared to zero by reset.
// R2: Gain field [18:16]: 0 unity, 1 x1.5, 2 x2, 3 x4, 4 and 5 x9.
// R3: Bit 15 low turns offset cancellation off, high turns it on.
// R4: Software uses gain 4 whenever offset cancellation runs with the amp.
// R5: Negative select in [12:8]; code zero leaves the input floating.
// R6: Negative codes 1, 2, 20: fast amp, low power amp, excitation amp.
// R7: Negative 4-7 aux 0-3, 8 bias cap, 11 thermal, 12 aux 4.
// R8: Positive select in [5:0]; 0 floats, 1 fast amp, 2 filtered amp.
// R9: Positive 0x0B thermal sensor, 0x13 its negative pin, 0x14 aux 4.
// R10: Positive 0x19 counter pin, 0x1A reference pin, 0x1F half counter.
// R11: Positive 0x21 low power amp out, 0x23 ground ref, 0x24 excitation.
// R12: Reserved selector codes are not written; treated as floating. Here they are stored in the config word; only the route floats.
`default_nettype none
module adcsel_top (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Gain stage selects, one-hot, and the raw gain code
   output logic gain_x1,
   output logic gain_x1p5,
   output logic gain_x2,
   output logic gain_x4,
   output logic gain_x9,
   output logic [adcsel_pkg::ADCSEL_GAIN_W-1:0] amp_gain_code,
   // Offset cancellation
   output logic offset_cancel_enable,
   // Negative multiplexer
   output logic [4:0] neg_input_select,
   output logic [31:0] neg_route,
   output logic neg_float,
   output logic neg_hs_tia,
   output logic neg_lp_tia,
   output logic [3:0] neg_aux,
   output logic neg_bias_capacitor_node,
   output logic neg_thermal_neg_output,
   output logic neg_aux4,
   output logic neg_exc_amp,
   // Positive multiplexer
   output logic [5:0] pos_input_select,
   output logic [63:0] pos_route,
   output logic pos_float,
   output logic pos_hs_tia,
   output logic pos_lp_filtered,
   output logic pos_thermal,
   output logic pos_thermal_neg_terminal,
   output logic pos_aux4,
   output logic pos_ce_pin,
   output logic pos_re_pin,
   output logic pos_ce_half,
   output logic pos_low_power_amp_pos_out,
   output logic pos_analog_ground_reference,
   output logic pos_exc_amp
);
   import adcsel_pkg::*;

   typedef struct packed {
      logic [31:0] cfg;
      logic [31:0] hrdata;
      logic hreadyout;
      logic [ADCSEL_GAIN_N-1:0] gain_sel;
      logic ofs_en;
      logic [31:0] neg_route;
      logic [63:0] pos_route;
   } adcsel_state_t;

   // Reset state: config clear, both inputs floating, unity gain
   localparam adcsel_state_t ADCSEL_STATE_RST = '{
      cfg: ADCSEL_CFG_RESET,
      hrdata: 32'h0000_0000,
      hreadyout: 1'b1,
      gain_sel: 5'h01,
      ofs_en: 1'b0,
      neg_route: 32'h0000_0001,
      pos_route: 64'h0000_0000_0000_0001
   };

   adcsel_state_t s_reg;
   adcsel_state_t s_next;

   logic rd_take;
   logic [31:0] rd_addr;
   logic wr_pend;
   logic [31:0] wr_addr;
   logic [31:0] cfg_new;
   logic [ADCSEL_GAIN_W-1:0] gain_new;
   logic [ADCSEL_NEG_W-1:0] neg_new;
   logic [ADCSEL_POS_W-1:0] pos_new;
   logic ofs_new;
   logic [31:0] neg_onehot;
   logic neg_rsv;
   logic [63:0] pos_onehot;
   logic pos_rsv;
   logic [31:0] status_new;

   // Gain code to one-hot gain stage select
   function automatic logic [ADCSEL_GAIN_N-1:0] gain_onehot(
      input logic [ADCSEL_GAIN_W-1:0] code
   );
      logic [ADCSEL_GAIN_N-1:0] sel;
      sel = '0;
      unique case (code)
         ADCSEL_GAIN_X1: sel = 5'h01; // R2
         ADCSEL_GAIN_X1P5: sel = 5'h02; // R2
         ADCSEL_GAIN_X2: sel = 5'h04; // R2
         ADCSEL_GAIN_X4: sel = 5'h08; // R2
         ADCSEL_GAIN_X9A,
         ADCSEL_GAIN_X9B: sel = 5'h10; // R2
         default: sel = 5'h01;
      endcase
      return sel;
   endfunction

   // Gain codes above the defined range
   function automatic logic gain_reserved(
      input logic [ADCSEL_GAIN_W-1:0] code
   );
      return code > ADCSEL_GAIN_X9B;
   endfunction

   // Bus address and data phase tracking
   adcsel_ahb_front u_front (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .haddr(haddr),
      .hready(hready),
      .rd_take(rd_take),
      .rd_addr(rd_addr),
      .wr_pend(wr_pend),
      .wr_addr(wr_addr)
   );

   // Config word after any write completing this cycle
   always_comb begin
      cfg_new = s_reg.cfg;
      if (wr_pend && wr_addr == ADCSEL_CFG_ADDR) begin
         cfg_new = hwdata & ADCSEL_CFG_WMASK; // R1
      end
   end

   // Field extraction
   assign gain_new = cfg_new[ADCSEL_GAIN_LSB +: ADCSEL_GAIN_W];
   assign ofs_new = cfg_new[ADCSEL_OFS_BIT]; // R3
   assign neg_new = cfg_new[ADCSEL_NEG_LSB +: ADCSEL_NEG_W]; // R5
   assign pos_new = cfg_new[ADCSEL_POS_LSB +: ADCSEL_POS_W]; // R8

   // Negative multiplexer decode
   adcsel_route_dec #(
      .W(ADCSEL_NEG_W),
      .N(32),
      .VALID(ADCSEL_NEG_VALID)
   ) u_neg_dec (
      .code(neg_new),
      .onehot(neg_onehot),
      .reserved(neg_rsv)
   );

   // Positive multiplexer decode
   adcsel_route_dec #(
      .W(ADCSEL_POS_W),
      .N(64),
      .VALID(ADCSEL_POS_VALID)
   ) u_pos_dec (
      .code(pos_new),
      .onehot(pos_onehot),
      .reserved(pos_rsv)
   );

   // Status word shows misprogramming of the config word
   always_comb begin
      status_new = 32'h0000_0000;
      status_new[ADCSEL_ST_NEG_RSV] = neg_rsv;
      status_new[ADCSEL_ST_POS_RSV] = pos_rsv;
      status_new[ADCSEL_ST_GAIN_RSV] = gain_reserved(gain_new);
      // Offset cancellation only supports gain 4
      status_new[ADCSEL_ST_OFS_CONFLICT] =
         ofs_new && gain_new != ADCSEL_GAIN_X4; // R4
   end

   // Next state: registers, read data and decoded selects
   always_comb begin
      s_next = s_reg;
      s_next.cfg = cfg_new;
      s_next.hreadyout = 1'b1;
      s_next.gain_sel = gain_onehot(gain_new); // R2
      s_next.ofs_en = ofs_new; // R3
      s_next.neg_route = neg_onehot; // R5
      s_next.pos_route = pos_onehot; // R8
      s_next.hrdata = 32'h0000_0000;
      if (rd_take) begin
         if (rd_addr == ADCSEL_CFG_ADDR) begin
            s_next.hrdata = cfg_new;
         end else if (rd_addr == ADCSEL_STAT_ADDR) begin
            s_next.hrdata = status_new;
         end
      end
   end

   // Single register stage for all state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_reg <= ADCSEL_STATE_RST; // R1
      end else begin
         s_reg <= s_next;
      end
   end

   // Bus outputs, zero wait states, always OKAY
   assign hrdata = s_reg.hrdata;
   assign hreadyout = s_reg.hreadyout;
   assign hresp = 1'b0;

   // Gain stage outputs
   assign gain_x1 = s_reg.gain_sel[0]; // R2
   assign gain_x1p5 = s_reg.gain_sel[1]; // R2
   assign gain_x2 = s_reg.gain_sel[2]; // R2
   assign gain_x4 = s_reg.gain_sel[3]; // R2
   assign gain_x9 = s_reg.gain_sel[4]; // R2
   assign amp_gain_code = s_reg.cfg[ADCSEL_GAIN_LSB +: ADCSEL_GAIN_W];

   // Offset cancellation control
   assign offset_cancel_enable = s_reg.ofs_en; // R3

   // Negative multiplexer outputs
   assign neg_input_select = s_reg.cfg[ADCSEL_NEG_LSB +: ADCSEL_NEG_W];
   assign neg_route = s_reg.neg_route;
   assign neg_float = s_reg.neg_route[ADCSEL_NEG_FLOAT]; // R5
   assign neg_hs_tia = s_reg.neg_route[ADCSEL_NEG_HS_TIA]; // R6
   assign neg_lp_tia = s_reg.neg_route[ADCSEL_NEG_LP_TIA]; // R6
   assign neg_aux = s_reg.neg_route[ADCSEL_NEG_AUX0 +: 4]; // R7
   assign neg_bias_capacitor_node =
      s_reg.neg_route[ADCSEL_NEG_BIAS_CAP]; // R7
   assign neg_thermal_neg_output =
      s_reg.neg_route[ADCSEL_NEG_THERMAL]; // R7
   assign neg_aux4 = s_reg.neg_route[ADCSEL_NEG_AUX4]; // R7
   assign neg_exc_amp = s_reg.neg_route[ADCSEL_NEG_EXC]; // R6

   // Positive multiplexer outputs
   assign pos_input_select = s_reg.cfg[ADCSEL_POS_LSB +: ADCSEL_POS_W];
   assign pos_route = s_reg.pos_route;
   assign pos_float = s_reg.pos_route[ADCSEL_POS_FLOAT]; // R8
   assign pos_hs_tia = s_reg.pos_route[ADCSEL_POS_HS_TIA]; // R8
   assign pos_lp_filtered = s_reg.pos_route[ADCSEL_POS_LP_FILT]; // R8
   assign pos_thermal = s_reg.pos_route[ADCSEL_POS_THERMAL]; // R9
   assign pos_thermal_neg_terminal =
      s_reg.pos_route[ADCSEL_POS_THERM_NEG]; // R9
   assign pos_aux4 = s_reg.pos_route[ADCSEL_POS_AUX4]; // R9
   assign pos_ce_pin = s_reg.pos_route[ADCSEL_POS_CE]; // R10
   assign pos_re_pin = s_reg.pos_route[ADCSEL_POS_RE]; // R10
   assign pos_ce_half = s_reg.pos_route[ADCSEL_POS_CE_HALF]; // R10
   assign pos_low_power_amp_pos_out =
      s_reg.pos_route[ADCSEL_POS_LP_OUT]; // R11
   assign pos_analog_ground_reference =
      s_reg.pos_route[ADCSEL_POS_AGND]; // R11
   assign pos_exc_amp = s_reg.pos_route[ADCSEL_POS_EXC]; // R11
endmodule
`default_nettype wire

/* File: verif/adcsel_top_asserts.sv */
`default_nettype none
module adcsel_top_asserts
   import adcsel_pkg::*;
(
   // Clock, reset and bus
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   // Decoded outputs
   input wire logic gain_x1,
   input wire logic gain_x4,
   input wire logic gain_x9,
   input wire logic [2:0] amp_gain_code,
   input wire logic offset_cancel_enable,
   input wire logic [4:0] neg_input_select,
   input wire logic [31:0] neg_route,
   input wire logic neg_float,
   input wire logic [5:0] pos_input_select,
   input wire logic [63:0] pos_route,
   input wire logic pos_float
);
   logic wr_q;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Marks the data phase of a word write to the config word
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
      end else begin
         wr_q <= hsel && hready && htrans[1] && hwrite
            && haddr == ADCSEL_CFG_ADDR && hsize == ADCSEL_HSIZE_WORD;
      end
   end
   chk_reset_clear: assert property ($rose(hresetn) |->
      amp_gain_code == 3'h0 && neg_float && pos_float
      && !offset_cancel_enable) else $error("config not cleared");
   chk_cfg_hold: assert property (!wr_q |=> $stable(amp_gain_code)
      && $stable(neg_input_select) && $stable(pos_input_select)
      && $stable(offset_cancel_enable)) else $error("config moved");
   chk_gain_write: assert property (wr_q |=>
      amp_gain_code == $past(hwdata[18:16])) else $error("gain field");
   chk_gain_decode: assert property (gain_x4 == (amp_gain_code == 3'h3)
      && gain_x9 == (amp_gain_code == 3'h4 || amp_gain_code == 3'h5)
      && gain_x1 == (amp_gain_code == 3'h0 || amp_gain_code > 3'h5))
      else $error("gain select");
   chk_ofs_write: assert property (wr_q |=>
      offset_cancel_enable == $past(hwdata[15])) else $error("offset bit");
   chk_neg_write: assert property (wr_q |=>
      neg_input_select == $past(hwdata[12:8])) else $error("neg field");
   chk_pos_write: assert property (wr_q |=>
      pos_input_select == $past(hwdata[5:0])) else $error("pos field");
   chk_neg_route: assert property (neg_route ==
      (ADCSEL_NEG_VALID[neg_input_select] ? 32'h1 << neg_input_select
      : 32'h1)) else $error("neg route");
   chk_pos_route: assert property (pos_route ==
      (ADCSEL_POS_VALID[pos_input_select] ? 64'h1 << pos_input_select
      : 64'h1)) else $error("pos route");
endmodule
`default_nettype wire

/* File: verif/adc_input_select_config_bench.sv */
`default_nettype none
module adc_input_select_config_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import adcsel_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [1:0] htrans;
   logic [2:0] hsize, amp_gain_code;
   logic [31:0] haddr, hwdata, hrdata, neg_route, rdat;
   logic gain_x1, gain_x1p5, gain_x2, gain_x4, gain_x9;
   logic offset_cancel_enable, neg_float, neg_exc_amp;
   logic pos_float, pos_exc_amp;
   logic [4:0] neg_input_select;
   logic [5:0] pos_input_select;
   logic [63:0] pos_route;
   int n_mismatch, checks_done;
   adcsel_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .gain_x1, .gain_x1p5, .gain_x2, .gain_x4, .gain_x9, .amp_gain_code,
      .offset_cancel_enable, .neg_input_select, .neg_route, .neg_float,
      .neg_hs_tia(), .neg_lp_tia(), .neg_aux(), .neg_bias_capacitor_node(),
      .neg_thermal_neg_output(), .neg_aux4(), .neg_exc_amp,
      .pos_input_select, .pos_route, .pos_float, .pos_hs_tia(),
      .pos_lp_filtered(), .pos_thermal(), .pos_thermal_neg_terminal(),
      .pos_aux4(), .pos_ce_pin(), .pos_re_pin(), .pos_ce_half(),
      .pos_low_power_amp_pos_out(), .pos_analog_ground_reference(),
      .pos_exc_amp);
   // Free-running bus clock
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic wait_ready();
      for (int n = 0; n < 20; n++) begin
         @(posedge hclk);
         if (hreadyout === 1'b1) return;
      end
      n_mismatch++;
      $display("mismatch at %0t: bus hang", $time);
      finish_test();
   endtask
   // One single transfer: address phase, then data phase
   task automatic xfer(input logic w, input logic [31:0] a,
         input logic [31:0] d, input logic [2:0] sz);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      hsize <= sz;
      htrans <= ADCSEL_HTRANS_NONSEQ;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      rdat = hrdata;
      @(negedge hclk);
   endtask
   task automatic t_reset();
      xfer(1'b0, ADCSEL_CFG_ADDR, 32'h0, ADCSEL_HSIZE_WORD);
      check(rdat, 64'h0);
      check({gain_x1, neg_float, pos_float, offset_cancel_enable}, 4'hE);
      check(hresp, 1'b0);
      $display("test reset done");
   endtask
   task automatic t_gain();
      logic [4:0] exp;
      for (int g = 0; g < 8; g++) begin
         exp = (g < 4) ? 5'h01 << g : (g < 6) ? 5'h10 : 5'h01;
         xfer(1'b1, ADCSEL_CFG_ADDR, 32'(g) << 16, ADCSEL_HSIZE_WORD);
         check({gain_x9, gain_x4, gain_x2, gain_x1p5, gain_x1}, exp);
         check(amp_gain_code, g[2:0]);
      end
      $display("test gain done");
   endtask
   task automatic t_ofs();
      xfer(1'b1, ADCSEL_CFG_ADDR, 32'h0003_8000, ADCSEL_HSIZE_WORD);
      check({offset_cancel_enable, gain_x4}, 2'h3);
      xfer(1'b0, ADCSEL_STAT_ADDR, 32'h0, ADCSEL_HSIZE_WORD);
      check(rdat, 64'h0);
      // Offset cancellation with a gain other than 4 is flagged
      xfer(1'b1, ADCSEL_CFG_ADDR, 32'h0001_8000, ADCSEL_HSIZE_WORD);
      xfer(1'b0, ADCSEL_STAT_ADDR, 32'h0, ADCSEL_HSIZE_WORD);
      check(rdat, 64'h8);
      xfer(1'b1, ADCSEL_CFG_ADDR, 32'h0003_0000, ADCSEL_HSIZE_WORD);
      check({offset_cancel_enable, gain_x4}, 2'h1);
      $display("test offset done");
   endtask
   task automatic t_neg();
      for (int c = 0; c < 32; c++) begin
         xfer(1'b1, ADCSEL_CFG_ADDR, 32'(c) << 8, ADCSEL_HSIZE_WORD);
         check(neg_input_select, c[4:0]);
         check(neg_route, ADCSEL_NEG_VALID[c] ? 64'h1 << c : 64'h1);
         check(neg_exc_amp, c == 20);
         check(neg_float, c == 0 || !ADCSEL_NEG_VALID[c]);
      end
      $display("test negative mux done");
   endtask
   task automatic t_pos();
      for (int c = 0; c < 64; c++) begin
         xfer(1'b1, ADCSEL_CFG_ADDR, 32'(c), ADCSEL_HSIZE_WORD);
         check(pos_input_select, c[5:0]);
         check(pos_route, ADCSEL_POS_VALID[c] ? 64'h1 << c : 64'h1);
         check(pos_exc_amp, c == 36);
      end
      $display("test positive mux done");
   endtask
   task automatic t_bus();
      xfer(1'b1, ADCSEL_CFG_ADDR, 32'hFFFF_FFFF, ADCSEL_HSIZE_WORD);
      xfer(1'b0, ADCSEL_CFG_ADDR, 32'h0, ADCSEL_HSIZE_WORD);
      check(rdat, ADCSEL_CFG_WMASK);
      // Byte write and unmapped write leave the word alone
      xfer(1'b1, ADCSEL_CFG_ADDR, 32'h0, 3'h0);
      xfer(1'b1, 32'h0000_21B0, 32'h0, ADCSEL_HSIZE_WORD);
      xfer(1'b0, ADCSEL_CFG_ADDR, 32'h0, ADCSEL_HSIZE_WORD);
      check(rdat, ADCSEL_CFG_WMASK);
      xfer(1'b0, 32'h0000_21B0, 32'h0, ADCSEL_HSIZE_WORD);
      check(rdat, 64'h0);
      $display("test bus done");
   endtask
   // Main sequence
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = ADCSEL_HSIZE_WORD;
      hwdata = 32'h0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_gain();
      t_ofs();
      t_neg();
      t_pos();
      t_bus();
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      finish_test();
   end
endmodule
bind adcsel_top adcsel_top_asserts u_chk (.hclk, .hresetn, .hsel, .haddr,
   .htrans, .hwrite, .hsize, .hwdata, .hready, .gain_x1, .gain_x4,
   .gain_x9, .amp_gain_code, .offset_cancel_enable, .neg_input_select,
   .neg_route, .neg_float, .pos_input_select, .pos_route, .pos_float);
`default_nettype wire
